// *** hdl/mpc_port.sv ***
// PHY side of the controller port: rank select, shadow set choice,
// write latency capture with clipping and calibration status handshake.
// Assumes controller keeps spacing, preamble and CRC idle rules.
`default_nettype none
module mpc_port
	import mpc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire mpc_wr_ctl_t wr_ctl,
	input wire logic [RATE-1:0] wdata_valid,
	input wire logic [RATE*8-1:0] wdata,
	input wire logic [RATE-1:0] write_data_mask,
	input wire mpc_rd_ctl_t rd_ctl,
	input wire logic [RATE-1:0] rdata_en,
	input wire logic cal_req,
	input wire logic cal_ok_in,
	input wire logic cal_done_in,
	input wire logic [LAT_W-1:0] wlat_meas,
	input wire logic out_ready,
	output logic out_valid,
	output logic [RATE*8+RATE-1:0] out_word,
	output logic [RATE-1:0][1:0] wr_set,
	output logic [RATE-1:0][1:0] rd_set,
	output logic [LAT_W-1:0] wlat,
	output logic [LAT_W-1:0] rlat,
	output logic cal_success,
	output logic cal_fail,
	output logic wr_stall
);
	function automatic logic [1:0] set_of(input logic [RANKS-1:0] r);
		logic [1:0] s;
		s = 2'h0;
		for (int i = 0; i < RANKS; i++)
			if (r[i])
				s = i[1:0];
		return s; // R3 R7
	endfunction
	mpc_cal_state_t st_reg, st_next;
	logic [$clog2(CAL_CYCLES+1)-1:0] cnt_reg;
	logic [LAT_W-1:0] wlat_reg;
	logic succ_reg, fail_reg;
	logic [RATE-1:0][1:0] wset_reg, rset_reg;
	logic [RATE-1:0][1:0] rset_next;
	logic [1:0] rhold_reg;
	logic fv_reg;
	logic [RATE*8+RATE-1:0] fw_reg;
	wire fin_ready;
	wire cnt_done = (cnt_reg == CAL_CYCLES[$bits(cnt_reg)-1:0]);
	wire [LAT_W-1:0] wlat_clip = (wlat_meas > WLAT_MAX) ? WLAT_MAX : wlat_meas; // R23
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			CAL_RESET: st_next = CAL_RUN;
			CAL_RUN: if (cal_done_in || cnt_done)
				st_next = (cal_done_in && cal_ok_in) ? CAL_PASS : CAL_FAIL; // R22
			CAL_PASS: st_next = CAL_PASS;
			CAL_FAIL: st_next = CAL_FAIL;
			default: st_next = CAL_RESET;
		endcase
		if (cal_req)
			st_next = CAL_RESET; // R20 R21
	end
	// Read set holds last rank until a new rank word arrives
	always_comb begin
		logic [1:0] h;
		h = rhold_reg;
		for (int t = 0; t < RATE; t++) begin
			if (rd_ctl.en_full[t] && rd_ctl.rank[t] != RANK_NONE)
				h = set_of(rd_ctl.rank[t]); // R2 R4 R17 R18
			rset_next[t] = h;
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_reg <= CAL_RESET;
			cnt_reg <= '0;
			wlat_reg <= WLAT_RESET;
			succ_reg <= 1'b0;
			fail_reg <= 1'b0;
		end else if (ce) begin
			st_reg <= st_next;
			cnt_reg <= (st_next == CAL_RUN) ? cnt_reg + 1'b1 : '0;
			if (st_next == CAL_PASS && st_reg == CAL_RUN)
				wlat_reg <= wlat_clip; // R11
			succ_reg <= (st_next == CAL_PASS); // R19 R24
			fail_reg <= (st_next == CAL_FAIL); // R19 R22
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wset_reg <= '0;
			rset_reg <= '0;
			rhold_reg <= 2'h0;
		end else if (ce) begin
			for (int t = 0; t < RATE; t++)
				if (wr_ctl.burst[t])
					wset_reg[t] <= set_of(wr_ctl.rank[t]); // R1 R4 R8
			rset_reg <= rset_next;
			rhold_reg <= rset_next[RATE-1];
		end
	end
	// Write beats already delayed by controller; slot order preserved, R9 R10 R12 R13
	// Inversion generated downstream from raw data, R14; CRC slots pass as given, R15 R16
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fv_reg <= 1'b0;
			fw_reg <= '0;
		end else if (ce && (fin_ready || !fv_reg)) begin
			fv_reg <= |wdata_valid && succ_reg;
			fw_reg <= {write_data_mask, wdata};
		end
	end
	mpc_fifo #(.WIDTH(RATE*8+RATE), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.ce(ce),
		.in_valid(fv_reg),
		.in_ready(fin_ready),
		.in_data(fw_reg),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(out_word)
	);
	assign wr_set = wset_reg;
	assign rd_set = rset_reg;
	assign wlat = wlat_reg;
	assign rlat = RLAT_RESET;
	assign cal_success = succ_reg;
	assign cal_fail = fail_reg;
	assign wr_stall = !fin_ready;
endmodule
`default_nettype wire

// *** hdl/mpc_pkg.sv ***
// Shared constants and carriers for the memory PHY controller port.
// Assumes one PHY clock domain; rate ratio fixed at quarter rate.
// Contract
// [R1] Write rank spans exactly the strobe burst
// [R2] Read rank given with enable, held
// [R3] Rank word is one-hot, bit0 first rank
// [R4] Rank bus ordered by slot, earliest lowest
// [R5] Cross-rank reads need three extra cycles
// [R6] Cross-rank writes need four extra cycles
// [R7] At most four calibrated timing sets kept
// [R8] Command phase n drives memory slot n
// [R9] Write data slot matches command slot
// [R10] Write signals delayed by write latency
// [R11] Latency unit is one PHY clock
// [R12] Strobe burst leads data by preamble
// [R13] DDR4 two-cycle preamble leads by two
// [R14] Bus inversion handled wholly inside PHY
// [R15] CRC mode forbids back-to-back writes
// [R16] CRC slots carry zero from controller
// [R17] Full read enable spans whole burst
// [R18] Full read enable starts in command slot
// [R19] Pass and fail low until calibration ends
// [R20] Calibration request reruns power-up sequence
// [R21] Calibration request is sequencer synchronous reset
// [R22] Fail raised when calibration fails
// [R23] Write latency within 0 to 63
// [R24] Pass low during any recalibration
`default_nettype none
package mpc_pkg;
	localparam int RATE = 4;
	localparam int RANKS = 4;
	localparam int SETS = 4;
	localparam int LAT_W = 6;
	localparam int FIFO_DEPTH = 16;
	localparam int CAL_TIME_US = 10;
	localparam int CLK_MHZ = 25;
	localparam int CAL_CYCLES = CAL_TIME_US * CLK_MHZ;
	localparam logic [LAT_W-1:0] WLAT_MAX = 6'h3f;
	localparam logic [LAT_W-1:0] WLAT_RESET = 6'h00;
	localparam logic [LAT_W-1:0] RLAT_RESET = 6'h00;
	localparam logic [RANKS-1:0] RANK_NONE = 4'h0;
	typedef struct packed {
		logic [RATE-1:0][RANKS-1:0] rank;
		logic [RATE-1:0] burst;
	} mpc_wr_ctl_t;
	typedef struct packed {
		logic [RATE-1:0][RANKS-1:0] rank;
		logic [RATE-1:0] en_full;
	} mpc_rd_ctl_t;
	typedef enum {CAL_RESET, CAL_RUN, CAL_PASS, CAL_FAIL} mpc_cal_state_t;
endpackage
`default_nettype wire

// *** hdl/mpc_fifo.sv ***
// Parameterised valid/ready FIFO.
// Assumes single clock, synchronous use.
`default_nettype none
module mpc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0] cnt_reg;
	wire push = ce && in_valid && in_ready;
	wire pop = ce && out_valid && out_ready;
	assign in_ready = (cnt_reg != DEPTH[AW:0]);
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem[rp_reg];
	always_ff @(posedge sys_clk) begin
		if (push)
			mem[wp_reg] <= in_data;
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push)
				wp_reg <= wp_reg + 1'b1;
			if (pop)
				rp_reg <= rp_reg + 1'b1;
			if (push && !pop)
				cnt_reg <= cnt_reg + 1'b1;
			else if (pop && !push)
				cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule
`default_nettype wire

// *** verif/mpc_port_asserts.sv ***
// Checker: calibration handshake and shadow set choice.
// Assumes one PHY clock; bound into each mpc_port.
`default_nettype none
module mpc_port_asserts
	import mpc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire mpc_wr_ctl_t wr_ctl,
	input wire mpc_rd_ctl_t rd_ctl,
	input wire logic cal_req,
	input wire logic cal_ok_in,
	input wire logic cal_done_in,
	input wire logic [LAT_W-1:0] wlat_meas,
	input wire logic [RATE-1:0][1:0] wr_set,
	input wire logic [RATE-1:0][1:0] rd_set,
	input wire logic [LAT_W-1:0] wlat,
	input wire logic cal_success,
	input wire logic cal_fail
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	function automatic logic [1:0] enc(logic [RANKS-1:0] r);
		return {r[3] | r[2], r[3] | r[1]};
	endfunction
	// Result seen one edge after done is sampled while calibration runs
	sequence run_done_s;
		$past(ce && !cal_req && !rst) ##0
			(ce && !cal_req && cal_done_in && !cal_success && !cal_fail);
	endsequence
	flag_excl_a: assert property (!(cal_success && cal_fail))
		else $error("both flags high");
	req_drop_a: assert property (cal_req |=> !cal_success && !cal_fail)
		else $error("flag kept in reset");
	done_result_a: assert property (run_done_s |=>
		cal_success == $past(cal_ok_in) && cal_fail != $past(cal_ok_in)) else $error("bad result");
	pass_cause_a: assert property ($rose(cal_success) |-> $past(cal_done_in && cal_ok_in))
		else $error("pass without done");
	lat_load_a: assert property ($rose(cal_success) |-> wlat == $past(wlat_meas))
		else $error("latency not loaded");
	pass_hold_a: assert property (cal_success && !cal_req |=> cal_success)
		else $error("pass dropped");
	for (genvar t = 0; t < RATE; t++) begin : g_slot
		wr_set_a: assert property (ce && cal_success && $onehot(wr_ctl.rank[t]) |=>
			wr_set[t] == enc($past(wr_ctl.rank[t]))) else $error("write set wrong");
		rd_set_a: assert property (ce && cal_success && $onehot(rd_ctl.rank[t]) |=>
			rd_set[t] == enc($past(rd_ctl.rank[t]))) else $error("read set wrong");
	end
endmodule
bind mpc_port mpc_port_asserts chk (.sys_clk, .rst, .ce, .wr_ctl, .rd_ctl, .cal_req, .cal_ok_in,
	.cal_done_in, .wlat_meas, .wr_set, .rd_set, .wlat, .cal_success, .cal_fail);
`default_nettype wire

// *** verif/mpc_ctrl_model.sv ***
// Controller model: rank selects, strobe burst, read enables.
// Assumes at most one access request per PHY clock.
`default_nettype none
module mpc_ctrl_model
	import mpc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic go,
	input wire logic [1:0] rank,
	output var mpc_wr_ctl_t wr_ctl,
	output var mpc_rd_ctl_t rd_ctl
);
	timeunit 1ns;
	timeprecision 100ps;
	always @(posedge sys_clk) begin
		wr_ctl <= #1 go ? {{RATE{4'h1 << rank}}, {RATE{1'b1}}} : '0;
		rd_ctl.en_full <= #1 {RATE{go}};
		if (go) rd_ctl.rank <= #1 {RATE{4'h1 << rank}};
	end
endmodule
`default_nettype wire

// *** verif/test_memory_phy_controller_port.sv ***
// Bench: calibration, shadow sets and write FIFO of mpc_port.
// Assumes 25 MHz clock; inputs change 1 ns after each edge.
`default_nettype none
module test_memory_phy_controller_port
	import mpc_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, go = 1'b0, cal_req = 1'b0, out_ready = 1'b0;
	logic cal_ok_in = 1'b0, cal_done_in = 1'b0, out_valid, wr_stall, cal_success, cal_fail;
	logic [1:0] rank = 2'h0;
	logic [3:0] wdata_valid = 4'h0, write_data_mask = 4'h5;
	logic [5:0] wlat_meas = 6'h3f, wlat;
	logic [31:0] wdata = 32'h0;
	logic [35:0] out_word;
	logic [3:0][1:0] wr_set, rd_set;
	mpc_wr_ctl_t wr_ctl;
	mpc_rd_ctl_t rd_ctl;
	int err_count = 0, check_count = 0;
	mpc_ctrl_model ctl (.sys_clk, .go, .rank, .wr_ctl, .rd_ctl);
	mpc_port dut (.sys_clk, .rst, .ce, .wr_ctl, .wdata_valid, .wdata, .write_data_mask, .rd_ctl,
		.rdata_en(rd_ctl.en_full), .cal_req, .cal_ok_in, .cal_done_in, .wlat_meas, .out_ready,
		.out_valid, .out_word, .wr_set, .rd_set, .wlat, .rlat(), .cal_success, .cal_fail, .wr_stall);
	initial forever #20 sys_clk = ~sys_clk;
	task automatic step(int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(logic [35:0] got, logic [35:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cal(logic req, logic good);
		cal_req = req;
		step(2);
		chk(36'({cal_success, cal_fail}), 36'h0);
		cal_req = 1'b0;
		cal_ok_in = good;
		step(2);
		cal_done_in = 1'b1;
		step(1);
		cal_done_in = 1'b0;
		chk(36'({cal_success, cal_fail}), 36'({good, !good}));
		$display("calibration done");
	endtask
	task automatic t_rank();
		chk(36'(wlat), 36'h3f);
		for (int r = 0; r < 4; r++) begin
			rank = r[1:0];
			go = 1'b1;
			step(1);
			go = 1'b0;
			step(2);
			chk(36'({wr_set, rd_set}), 36'({8{r[1:0]}}));
		end
		$display("rank done");
	endtask
	task automatic t_fifo();
		int n = 0;
		wdata_valid = 4'hf;
		while (wr_stall !== 1'b1 && n < 40) begin
			wdata = {8{n[3:0]}};
			n++;
			step(1);
		end
		wdata_valid = 4'h0;
		// Input stage register holds one beat beyond the FIFO depth
		chk(36'(n), 36'(FIFO_DEPTH + 1));
		out_ready = 1'b1;
		for (int i = 0; i < FIFO_DEPTH + 1; i++) begin
			chk(out_word, {4'h5, {8{i[3:0]}}});
			step(1);
		end
		chk(36'({out_valid, wr_stall}), 36'h0);
		$display("fifo done");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		step(10);
		rst = 1'b0;
		cal(1'b0, 1'b1);
		t_rank();
		t_fifo();
		cal(1'b1, 1'b0);
		cal(1'b1, 1'b1);
		complete_run();
	end
endmodule
`default_nettype wire
